// File: logic/mcu_irq_controller.sv
`timescale 1ns/10ps
// What this block does
// [R1] Accepting an interrupt clears the global enable bit.
// [R2] Return completion sets global enable; software may also write it.
// [R3] Vectoring to a source clears that source's pending flag.
// [R4] Flags set and hold while their own enable is zero.
// [R5] Flags held while global enable is zero are served later, one by one.
// [R6] Low-level external mode has no flag; request follows the pin level.
// [R7] Status register is neither saved on entry nor restored on return.
// [R8] Entry halts the core four cycles while the 9-bit PC is pushed.
// [R9] Entry starts only at an instruction boundary, or from idle while the core is sleeping.
// [R10] Waking from sleep adds four more entry cycles.
// [R11] Return takes four cycles while the 9-bit PC is popped.
// [R12] After return, one main instruction completes before the next entry.
// [R13] External mask bit 6 enables the pin interrupt, vector 001 hex.
// [R14] The external pin raises requests even when configured as output.
// [R15] External mask bit 5 enables pin change, vector 002 hex.
// [R16] External flag bit 6 sets on pin event, clears on vector or one-write.
// [R17] Pin change flag bit 5 sets on change, clears on vector or one-write.
// [R18] Timer flag bit 6 compare match, mask bit 6, vector 003 hex.
// [R19] Timer flag bit 2 timer1 overflow, mask bit 2, vector 004 hex.
// [R20] Timer flag bit 1 timer0 overflow, mask bit 1, vector 005 hex.
// [R21] Writing one to a timer flag clears it.
// [R22] Reserved mask and flag bits read as zero.
// [R23] Lowest vector address wins among pending sources.
// [R24] Writing zero to a flag leaves it unchanged.
module mcu_irq_controller #(
    parameter int PORT_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [mcu_irq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_pin,
    input wire logic [PORT_W-1:0] port_pins,
    input wire logic t1_compare_match,
    input wire logic t1_overflow,
    input wire logic t0_overflow,
    input wire logic cpu_instr_boundary,
    input wire logic cpu_sleeping,
    input wire logic return_from_irq_instr,
    output logic cpu_halt,
    output logic return_busy,
    output logic irq_vector_valid,
    output logic [mcu_irq_pkg::PC_W-1:0] irq_vector_addr
);
    import mcu_irq_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic [2:0] cnt;
        logic [2:0] src;
        logic global_irq_enable;
        logic [1:0] ext_sense_sel;
        logic [7:0] external_irq_mask;
        logic [7:0] timer_irq_mask;
        logic [NUM_SRC-1:0] flags;
        logic waitreq;
        logic [31:0] readdata;
        logic halt;
        logic ret_busy;
        logic vec_valid;
        logic [PC_W-1:0] vec_addr;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic ext_event;
    logic ext_level_low;
    logic pin_change;

    // ==========================================================
    // Pin synchronisation and event detection.
    // ==========================================================
    pin_event_detect #(
        .PORT_W(PORT_W)
    ) u_pin_event_detect (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .ext_pin(ext_pin),
        .port_pins(port_pins),
        .ext_sense_sel(s.ext_sense_sel),
        .ext_event(ext_event),
        .ext_level_low(ext_level_low),
        .pin_change(pin_change)
    );

    // ==========================================================
    // Request, enable and priority terms.
    // ==========================================================
    logic level_mode;
    logic [NUM_SRC-1:0] hw_set;
    logic [NUM_SRC-1:0] enables;
    logic [NUM_SRC-1:0] requests;
    logic [NUM_SRC-1:0] pending;
    logic [2:0] winner;
    logic [5:0] reg_idx;
    logic addr_ok;
    logic [7:0] rd_byte;

    // Hardware events per source, in priority order.
    always_comb begin
        level_mode = s.ext_sense_sel == SENSE_LOW_LEVEL;

        hw_set[SRC_EXT_PIN] = ext_event && !level_mode; // [R16]
        hw_set[SRC_PIN_CHANGE] = pin_change; // [R17]
        hw_set[SRC_T1_COMPARE] = t1_compare_match; // [R18]
        hw_set[SRC_T1_OVERFLOW] = t1_overflow; // [R19]
        hw_set[SRC_T0_OVERFLOW] = t0_overflow; // [R20]

        enables[SRC_EXT_PIN] = s.external_irq_mask[BIT_EXT_PIN]; // [R13]
        enables[SRC_PIN_CHANGE] = s.external_irq_mask[BIT_PIN_CHANGE]; // [R15]
        enables[SRC_T1_COMPARE] = s.timer_irq_mask[BIT_T1_COMPARE];
        enables[SRC_T1_OVERFLOW] = s.timer_irq_mask[BIT_T1_OVERFLOW];
        enables[SRC_T0_OVERFLOW] = s.timer_irq_mask[BIT_T0_OVERFLOW];

        requests = s.flags;
        // The level request lives only while the pin stays low. [R6]
        requests[SRC_EXT_PIN] = level_mode ? ext_level_low : s.flags[SRC_EXT_PIN];
        // A flag with its enable off stays latched but does not request. [R4]
        pending = requests & enables;
    end

    // Scan from the lowest priority up so the lowest index is left standing. [R23]
    always_comb begin
        winner = SRC_EXT_PIN;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                winner = 3'(i);
            end
        end
    end

    // ==========================================================
    // Register read mux.
    // ==========================================================
    // Reserved bits come out as zero because only defined fields are placed. [R22]
    always_comb begin
        reg_idx = avs_address[ADDR_W-1:2];
        addr_ok = avs_address[1:0] == 2'b00;
        rd_byte = 8'h00;

        if (addr_ok) begin
            case (reg_idx)
                IDX_TIMER_IRQ_FLAGS: begin
                    rd_byte[BIT_T1_COMPARE] = s.flags[SRC_T1_COMPARE];
                    rd_byte[BIT_T1_OVERFLOW] = s.flags[SRC_T1_OVERFLOW];
                    rd_byte[BIT_T0_OVERFLOW] = s.flags[SRC_T0_OVERFLOW];
                end
                IDX_EXTERNAL_IRQ_FLAGS: begin
                    rd_byte[BIT_EXT_PIN] = s.flags[SRC_EXT_PIN] && !level_mode; // [R16]
                    rd_byte[BIT_PIN_CHANGE] = s.flags[SRC_PIN_CHANGE];
                end
                IDX_TIMER_IRQ_MASK: rd_byte = s.timer_irq_mask & TIMER_MASK_RW;
                IDX_EXTERNAL_IRQ_MASK: rd_byte = s.external_irq_mask & EXT_MASK_RW;
                IDX_IRQ_CONTROL: begin
                    rd_byte[BIT_GLOBAL_ENABLE] = s.global_irq_enable;
                    rd_byte[SENSE_LSB +: 2] = s.ext_sense_sel;
                end
                IDX_IRQ_STATUS: begin
                    rd_byte[2:0] = s.state;
                    rd_byte[STATUS_SRC_LSB +: 3] = s.src;
                end
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Next-state logic: bus slave, flags and entry/return sequencer.
    // ==========================================================
    logic bus_req;
    logic bus_take;
    logic sw_write;
    logic [7:0] wbyte;
    logic [NUM_SRC-1:0] sw_clear;
    logic [NUM_SRC-1:0] vec_clear;
    logic accept;

    always_comb begin
        next_s = s;
        bus_req = avs_read || avs_write;
        bus_take = bus_req && !s.waitreq;
        sw_write = bus_take && avs_write && avs_byteenable[0] && addr_ok;
        wbyte = avs_writedata[7:0];
        sw_clear = '0;
        vec_clear = '0;
        accept = 1'b0;

        if (ce) begin
            // One wait cycle per access; read data is captured when the wait drops.
            next_s.waitreq = !(bus_req && s.waitreq);
            if (bus_req && s.waitreq) begin
                next_s.readdata = {24'h000000, rd_byte};
            end

            next_s.vec_valid = 1'b0;

            // Register writes.
            if (sw_write) begin
                case (reg_idx)
                    IDX_TIMER_IRQ_FLAGS: begin
                        sw_clear[SRC_T1_COMPARE] = wbyte[BIT_T1_COMPARE]; // [R21]
                        sw_clear[SRC_T1_OVERFLOW] = wbyte[BIT_T1_OVERFLOW]; // [R21]
                        sw_clear[SRC_T0_OVERFLOW] = wbyte[BIT_T0_OVERFLOW]; // [R21]
                    end
                    IDX_EXTERNAL_IRQ_FLAGS: begin
                        sw_clear[SRC_EXT_PIN] = wbyte[BIT_EXT_PIN]; // [R16]
                        sw_clear[SRC_PIN_CHANGE] = wbyte[BIT_PIN_CHANGE]; // [R17]
                    end
                    IDX_TIMER_IRQ_MASK: next_s.timer_irq_mask = wbyte & TIMER_MASK_RW;
                    IDX_EXTERNAL_IRQ_MASK: next_s.external_irq_mask = wbyte & EXT_MASK_RW;
                    IDX_IRQ_CONTROL: begin
                        next_s.global_irq_enable = wbyte[BIT_GLOBAL_ENABLE]; // [R2]
                        next_s.ext_sense_sel = wbyte[SENSE_LSB +: 2];
                    end
                    default: next_s.cnt = s.cnt;
                endcase
            end

            // Sequencer.
            case (s.state)
                ST_IDLE, ST_POST_RETURN: begin
                    // Held flags wait here until global enable returns. [R5]
                    // Entry waits for the running instruction to finish. [R9]
                    // After a return, the first boundary ends the one main instruction. [R12]
                    accept = s.global_irq_enable && (|pending)
                        && (cpu_instr_boundary || (cpu_sleeping && s.state == ST_IDLE));
                    if (accept) begin
                        next_s.src = winner; // [R23]
                        next_s.global_irq_enable = 1'b0; // [R1]
                        next_s.halt = 1'b1;
                        if (cpu_sleeping) begin
                            next_s.state = ST_WAKE; // [R10]
                            next_s.cnt = WAKE_EXTRA_CYCLES - 3'd1;
                        end else begin
                            next_s.state = ST_ENTRY; // [R8]
                            next_s.cnt = ENTRY_CYCLES - 3'd1;
                        end
                    end else if (s.state == ST_POST_RETURN) begin
                        if (cpu_instr_boundary) begin
                            next_s.state = ST_IDLE; // [R12]
                        end
                    end else if (return_from_irq_instr) begin
                        next_s.state = ST_RETURN; // [R11]
                        next_s.cnt = RETURN_CYCLES - 3'd1;
                        next_s.ret_busy = 1'b1;
                    end
                end

                ST_WAKE: begin
                    next_s.cnt = s.cnt - 3'd1;
                    if (s.cnt == 3'd0) begin
                        next_s.state = ST_ENTRY; // [R10]
                        next_s.cnt = ENTRY_CYCLES - 3'd1;
                    end
                end

                ST_ENTRY: begin
                    // The core pushes its PC while halted; no status copy is taken. [R7]
                    next_s.cnt = s.cnt - 3'd1;
                    if (s.cnt == 3'd0) begin
                        next_s.state = ST_IDLE; // [R8]
                        next_s.halt = 1'b0;
                        next_s.vec_valid = 1'b1;
                        next_s.vec_addr = VECTOR_BASE + PC_W'(s.src); // [R13]
                        for (int i = 0; i < NUM_SRC; i++) begin
                            vec_clear[i] = s.src == 3'(i); // [R3]
                        end
                    end
                end

                ST_RETURN: begin
                    next_s.cnt = s.cnt - 3'd1;
                    if (s.cnt == 3'd0) begin
                        next_s.state = ST_POST_RETURN; // [R11]
                        next_s.ret_busy = 1'b0;
                        next_s.global_irq_enable = 1'b1; // [R2]
                    end
                end
                default: begin
                    next_s.state = ST_IDLE;
                    next_s.halt = 1'b0;
                    next_s.ret_busy = 1'b0;
                end
            endcase

            // A new event beats a clear in the same cycle; a zero write clears nothing. [R24]
            for (int i = 0; i < NUM_SRC; i++) begin
                next_s.flags[i] = hw_set[i] || (s.flags[i] && !sw_clear[i] && !vec_clear[i]); // [R4]
            end
            // In level mode the external flag is held at zero. [R6]
            if (next_s.ext_sense_sel == SENSE_LOW_LEVEL) begin
                next_s.flags[SRC_EXT_PIN] = 1'b0; // [R16]
            end
        end
    end

    // ==========================================================
    // State register.
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s.state <= ST_IDLE;
            s.cnt <= 3'd0;
            s.src <= SRC_EXT_PIN;
            s.global_irq_enable <= 1'b0;
            s.ext_sense_sel <= SENSE_RESET;
            s.external_irq_mask <= EXT_MASK_RESET;
            s.timer_irq_mask <= TIMER_MASK_RESET;
            s.flags <= FLAGS_RESET;

            s.waitreq <= 1'b1;
            s.readdata <= 32'h00000000;
            s.halt <= 1'b0;
            s.ret_busy <= 1'b0;
            s.vec_valid <= 1'b0;
            s.vec_addr <= 9'h000;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs, each straight from the state register.
    // ==========================================================
    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitreq;
    assign cpu_halt = s.halt;
    assign return_busy = s.ret_busy;
    assign irq_vector_valid = s.vec_valid;
    assign irq_vector_addr = s.vec_addr;

endmodule

// File: logic/mcu_irq_pkg.sv
package mcu_irq_pkg;

    // ==========================================================
    // Register indices; the byte address is four times the index.
    // ==========================================================
    localparam logic [5:0] IDX_TIMER_IRQ_FLAGS = 6'h38;
    localparam logic [5:0] IDX_TIMER_IRQ_MASK = 6'h39;
    localparam logic [5:0] IDX_EXTERNAL_IRQ_FLAGS = 6'h3A;
    localparam logic [5:0] IDX_EXTERNAL_IRQ_MASK = 6'h3B;
    localparam logic [5:0] IDX_IRQ_CONTROL = 6'h3C;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h3D;
    localparam int ADDR_W = 8;

    // ==========================================================
    // Field positions.
    // ==========================================================
    localparam int BIT_EXT_PIN = 6;
    localparam int BIT_PIN_CHANGE = 5;
    localparam int BIT_T1_COMPARE = 6;
    localparam int BIT_T1_OVERFLOW = 2;
    localparam int BIT_T0_OVERFLOW = 1;
    localparam int BIT_GLOBAL_ENABLE = 7;
    localparam int SENSE_LSB = 0;
    localparam int STATUS_SRC_LSB = 4;

    // Writable bits of each mask register; all other bits read as zero.
    localparam logic [7:0] EXT_MASK_RW = 8'h60;
    localparam logic [7:0] TIMER_MASK_RW = 8'h46;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [7:0] EXT_MASK_RESET = 8'h00;
    localparam logic [7:0] TIMER_MASK_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [1:0] SENSE_RESET = 2'h0;

    // ==========================================================
    // Sources, in priority order, lowest index wins.
    // ==========================================================
    localparam int NUM_SRC = 5;
    localparam logic [2:0] SRC_EXT_PIN = 3'h0;
    localparam logic [2:0] SRC_PIN_CHANGE = 3'h1;
    localparam logic [2:0] SRC_T1_COMPARE = 3'h2;
    localparam logic [2:0] SRC_T1_OVERFLOW = 3'h3;
    localparam logic [2:0] SRC_T0_OVERFLOW = 3'h4;
    localparam logic [8:0] VECTOR_BASE = 9'h001;
    localparam int PC_W = 9;

    // ==========================================================
    // External pin sense selection.
    // ==========================================================
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_ANY_CHANGE = 2'b01,
        SENSE_FALLING = 2'b10,
        SENSE_RISING = 2'b11
    } sense_t;

    // ==========================================================
    // Timing counts in clock cycles.
    // ==========================================================
    localparam logic [2:0] ENTRY_CYCLES = 3'd4;
    localparam logic [2:0] WAKE_EXTRA_CYCLES = 3'd4;
    localparam logic [2:0] RETURN_CYCLES = 3'd4;

    // ==========================================================
    // Sequencer states.
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_ENTRY = 3'b010,
        ST_RETURN = 3'b011,
        ST_POST_RETURN = 3'b100
    } seq_state_t;

endpackage

// File: logic/pin_event_detect.sv
`timescale 1ns/10ps
module pin_event_detect #(
    parameter int PORT_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic ext_pin,
    input wire logic [PORT_W-1:0] port_pins,
    input wire logic [1:0] ext_sense_sel,
    output logic ext_event,
    output logic ext_level_low,
    output logic pin_change
);
    import mcu_irq_pkg::*;

    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic [PORT_W-1:0] pins_s1;
        logic [PORT_W-1:0] pins_s2;
        logic [PORT_W-1:0] pins_prev;
        logic [1:0] primed;
    } detect_state_t;

    detect_state_t s;
    detect_state_t next_s;

    // ==========================================================
    // Synchronisers and previous-sample registers.
    // ==========================================================
    // Edges are ignored until the chain has filled, so that reset values give no false change.
    always_comb begin
        next_s = s;
        if (ce) begin
            next_s.ext_s1 = ext_pin;
            next_s.ext_s2 = s.ext_s1;
            next_s.ext_prev = s.ext_s2;
            next_s.pins_s1 = port_pins;
            next_s.pins_s2 = s.pins_s1;
            next_s.pins_prev = s.pins_s2;
            if (s.primed != 2'h3) begin
                next_s.primed = s.primed + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The pin level is read whatever its direction, so software can drive it to interrupt. [R14]
    always_comb begin
        ext_level_low = !s.ext_s2 && (s.primed == 2'h3);
        pin_change = (s.pins_s2 != s.pins_prev) && (s.primed == 2'h3); // [R15]
        case (sense_t'(ext_sense_sel))
            SENSE_ANY_CHANGE: ext_event = s.ext_s2 != s.ext_prev;
            SENSE_FALLING: ext_event = s.ext_prev && !s.ext_s2;
            SENSE_RISING: ext_event = !s.ext_prev && s.ext_s2;
            default: ext_event = 1'b0;
        endcase
        if (s.primed != 2'h3) begin
            ext_event = 1'b0;
        end
    end

endmodule

// File: tb/mcu_irq_properties.sv
`timescale 1ns/10ps
// ============================================================
// Entry, return and bus answer checks seen at the controller pins.
module mcu_irq_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_instr_boundary,
    input wire logic cpu_sleeping,
    input wire logic return_from_irq_instr,
    input wire logic cpu_halt,
    input wire logic return_busy,
    input wire logic irq_vector_valid,
    input wire logic [mcu_irq_pkg::PC_W-1:0] irq_vector_addr
);
    logic [1:0] bnd_cnt;
    // Boundaries since the last return, saturating at two; reset counts as long ago.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bnd_cnt <= 2'h2;
        end else if (ce && return_busy) begin
            bnd_cnt <= 2'h0;
        end else if (ce && cpu_instr_boundary && bnd_cnt != 2'h2) begin
            bnd_cnt <= bnd_cnt + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);
    chk_entry_four: assert property ($rose(cpu_halt) && !$past(cpu_sleeping)
        |-> cpu_halt[*4] ##1 (irq_vector_valid && !cpu_halt)) else $error("entry not four cycles");
    chk_wake_eight: assert property ($rose(cpu_halt) && $past(cpu_sleeping)
        |-> cpu_halt[*8] ##1 irq_vector_valid) else $error("wake entry not eight cycles");
    chk_return_four: assert property ($rose(return_busy) |-> $past(return_from_irq_instr)
        ##0 return_busy[*4] ##1 !return_busy) else $error("return not four cycles");
    chk_vector_pulse: assert property (irq_vector_valid |->
        ($past(cpu_halt) && !cpu_halt) ##1 !irq_vector_valid) else $error("vector pulse wrong");
    chk_vector_range: assert property (irq_vector_valid |->
        irq_vector_addr inside {[9'h001:9'h005]}) else $error("vector out of range");
    chk_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_entry_boundary: assert property ($rose(cpu_halt) |->
        $past(cpu_instr_boundary) || $past(cpu_sleeping)) else $error("entry mid instruction");
    chk_one_instr: assert property ($rose(cpu_halt) |-> bnd_cnt != 2'h0)
        else $error("entry too soon after return");
    cover property ($rose(cpu_halt) && $past(cpu_sleeping));
    cover property ($rose(return_busy));
    cover property (irq_vector_valid && irq_vector_addr == 9'h005);
endmodule
bind mcu_irq_controller mcu_irq_properties props (.*);

// File: tb/cpu_core_model.sv
`timescale 1ns/10ps
// ============================================================
// Core stand-in: finishes one multi-cycle instruction every GAP cycles.
module cpu_core_model #(
    parameter int GAP = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpu_halt,
    input wire logic return_busy,
    input wire logic irq_vector_valid,
    input wire logic ret_req,
    output logic cpu_instr_boundary,
    output logic return_from_irq_instr
);
    logic [3:0] cnt;
    // The core stalls while halted or popping, so no boundary can split an entry.
    always_ff @(posedge clk) begin
        cpu_instr_boundary <= 1'b0;
        return_from_irq_instr <= 1'b0;
        if (!rst_n || cpu_halt || return_busy || irq_vector_valid) begin
            cnt <= 4'h0;
        end else if (cnt == 4'(GAP - 1)) begin
            cnt <= 4'h0;
            cpu_instr_boundary <= !ret_req;
            return_from_irq_instr <= ret_req;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// File: tb/mcu_interrupt_handler_tb.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the interrupt controller.
module mcu_interrupt_handler_tb;
    import mcu_irq_pkg::*;
    localparam logic [7:0] TF = {IDX_TIMER_IRQ_FLAGS, 2'b00};
    localparam logic [7:0] TM = {IDX_TIMER_IRQ_MASK, 2'b00};
    localparam logic [7:0] EF = {IDX_EXTERNAL_IRQ_FLAGS, 2'b00};
    localparam logic [7:0] EM = {IDX_EXTERNAL_IRQ_MASK, 2'b00};
    localparam logic [7:0] CT = {IDX_IRQ_CONTROL, 2'b00};
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ext_pin = 1'b1;
    logic t1_compare_match = 1'b0, t1_overflow = 1'b0, t0_overflow = 1'b0;
    logic cpu_sleeping = 1'b0, ret_req = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [5:0] port_pins = 6'h00;
    logic [8:0] irq_vector_addr;
    logic avs_waitrequest, cpu_instr_boundary, return_from_irq_instr, cpu_halt, return_busy;
    logic irq_vector_valid;
    int num_errors = 0, n_tests = 0;
    mcu_irq_controller uut (.*, .ce(1'b1), .avs_byteenable(4'hF));
    cpu_core_model core (.*);
    // 200 MHz clock.
    always #2.5 clk = ~clk;
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", w, e, g);
            num_errors++;
        end
    endtask
    // One Avalon access; the idle edge at the end keeps requests from colliding.
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !we;
        avs_write <= we;
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(w, {24'h0, e}, q);
    endtask
    task automatic tmr(input logic [2:0] p);
        {t1_compare_match, t1_overflow, t0_overflow} <= p;
        @(posedge clk);
        {t1_compare_match, t1_overflow, t0_overflow} <= 3'h0;
        @(posedge clk);
    endtask
    task automatic wait_vec(input logic [8:0] v);
        while (irq_vector_valid !== 1'b1) @(posedge clk);
        check("vector", {23'h0, v}, {23'h0, irq_vector_addr});
        @(posedge clk);
    endtask
    task automatic do_ret();
        ret_req <= 1'b1;
        while (return_busy !== 1'b1) @(posedge clk);
        ret_req <= 1'b0;
        while (return_busy !== 1'b0) @(posedge clk);
    endtask
    // Reset values, reserved bits and an unmapped address.
    task automatic regs_scenario();
        rd("tflags", TF, 8'h00);
        rd("emask", EM, 8'h00);
        wr(TM, 8'hFF);
        wr(EM, 8'hFF);
        rd("tmask", TM, 8'h46);
        rd("emask", EM, 8'h60);
        rd("unmapped", 8'hFC, 8'h00);
    endtask
    // Masked flags latch; zero writes keep them, one writes clear them.
    task automatic flags_scenario();
        wr(TM, 8'h00);
        tmr(3'h7);
        rd("tflags", TF, 8'h46);
        wr(TF, 8'h00);
        rd("tflags", TF, 8'h46);
        wr(TF, 8'h40);
        rd("tflags", TF, 8'h06);
    endtask
    // Pending timer sources wait for global enable, then go one by one.
    task automatic timer_scenario();
        wr(TM, 8'h46);
        tmr(3'h4);
        repeat (10) @(posedge clk);
        check("halt", 32'h0, {31'h0, cpu_halt});
        wr(CT, 8'h80);
        wait_vec(9'h003);
        rd("control", CT, 8'h00);
        rd("tflags", TF, 8'h06);
        do_ret();
        wait_vec(9'h004);
        do_ret();
        wait_vec(9'h005);
        do_ret();
        rd("control", CT, 8'h80);
    endtask
    // Events on the external pin and on a port pin raise both external sources; the pin one goes first.
    task automatic pin_scenario();
        wr(CT, 8'h01);
        ext_pin <= 1'b0;
        port_pins <= 6'h01;
        repeat (6) @(posedge clk);
        rd("eflags", EF, 8'h60);
        wr(CT, 8'h81);
        wait_vec(9'h001);
        do_ret();
        wait_vec(9'h002);
        do_ret();
    endtask
    // A held low level wakes a sleeping core and leaves no flag behind.
    task automatic sleep_scenario();
        cpu_sleeping <= 1'b1;
        wr(CT, 8'h80);
        wait_vec(9'h001);
        rd("eflags", EF, 8'h00);
        wr(CT, 8'h03);
        ext_pin <= 1'b1;
        cpu_sleeping <= 1'b0;
        repeat (4) @(posedge clk);
        rd("eflags", EF, 8'h40);
        wr(EF, 8'h40);
        rd("eflags", EF, 8'h00);
        do_ret();
    endtask
    // Main sequence after a five-cycle reset.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regs_scenario();
        flags_scenario();
        timer_scenario();
        pin_scenario();
        sleep_scenario();
        conclude();
    end
    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
